// [decode_pkg.sv]
// types shared by the decode block and its testbench
// assumes mcu_decode_defs.svh is compiled alongside
package decode_pkg;

	typedef enum logic [2:0] {
		CLS_NOP,
		CLS_BYTE,
		CLS_BIT,
		CLS_LITERAL,
		CLS_CONTROL,
		CLS_MOVE,
		CLS_EXTENDED
	} instr_class_t;

	typedef enum logic [2:0] {
		SEQ_EXEC,
		SEQ_SECOND,
		SEQ_FLUSH,
		SEQ_SKIP,
		SEQ_SKIP_SECOND
	} seq_state_t;

	typedef enum logic [1:0] {
		FORM_NONE,
		FORM_SHORT8,
		FORM_REL11,
		FORM_LONG20
	} ctl_form_t;

endpackage

// [instruction_phase_gen.sv]
// divides the oscillator clock into instruction-cycle phases
// assumes a synchronous active-high reset on the same clock
`include "mcu_decode_defs.svh"

module instruction_phase_gen #(
	parameter int PHASES = `OSC_PER_CYCLE
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	phase_if.gen ph
);

	generate
		if (PHASES < 2 || PHASES > 4)
		begin : g_bad_phases
			$error("PHASES must lie between 2 and 4");
		end
	endgenerate

	localparam logic [1:0] LAST = 2'(PHASES - 1);

	logic [1:0] count;
	wire at_last = (count == LAST);
	wire [1:0] next_count = at_last ? 2'h0 : 2'(count + 2'h1);

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			count <= 2'h0;
		else
			count <= next_count;
	end

	assign ph.phase = count;
	assign ph.cycle_start = (count == 2'h0);
	assign ph.cycle_end = at_last;

endmodule // instruction_phase_gen

// [mcu_decode_defs.svh]
// constants for the instruction fetch, decode and timing block
// assumes a 16-bit program word and a 20-bit program word address
`ifndef MCU_DECODE_DEFS_SVH
`define MCU_DECODE_DEFS_SVH

`define OSC_PER_CYCLE 4
`define RESET_VECTOR 20'h00000
`define WORD_W 16
`define PC_W_DEFAULT 20

// top nibble of every second word
`define SECOND_WORD_TAG 4'hf
`define OPC_MSB 15
`define OPC_LSB 12

// byte and bit operand fields
`define FILE_MSB 7
`define ACCESS_BIT 8
`define DEST_BIT 9
`define BITNUM_MSB 11
`define BITNUM_LSB 9

// access ram split and the two banks it maps onto
`define ACCESS_SPLIT 8'h60
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hf

// one-word call with extended set enabled
`define CALL_INDIRECT_WORD 16'h0014

`endif

// [mcu_instruction_decode_timing.sv]
// instruction fetch, decode and execution timing for the 8-bit core
// assumes program memory returns pm_data_i for pm_addr_o within one instruction cycle,
// and the alu reports skip_true_i / pc_load_i during the last phase of a cycle
`include "mcu_decode_defs.svh"

module mcu_instruction_decode_timing #(
	parameter int PC_W = `PC_W_DEFAULT
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	output logic [PC_W-1:0] pm_addr_o,
	output logic pm_rd_o,
	input wire logic [15:0] pm_data_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic extended_en_i,
	input wire logic skip_true_i,
	input wire logic pc_load_i,
	input wire logic [PC_W-1:0] pc_target_i,
	output logic cycle_start_o,
	output logic cycle_end_o,
	output logic execute_o,
	output logic nop_cycle_o,
	output logic second_word_o,
	output logic two_word_o,
	output decode_pkg::instr_class_t instr_class_o,
	output logic [7:0] file_addr_o,
	output logic [11:0] ram_addr_o,
	output logic dest_file_o,
	output logic banked_o,
	output logic [2:0] bit_num_o,
	output logic [7:0] literal_o,
	output logic [11:0] literal_long_o,
	output logic [1:0] pointer_sel_o,
	output logic [11:0] move_src_o,
	output logic [11:0] move_dst_o,
	output logic [19:0] prog_addr_o,
	output logic fast_o,
	output logic [1:0] table_mode_o,
	output logic skip_type_o
);

	generate
		if (PC_W < 20 || PC_W > 24)
		begin : g_bad_pc
			$error("PC_W must lie between 20 and 24");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic [3:0] top_of(input logic [15:0] w);
		top_of = w[`OPC_MSB:`OPC_LSB];
	endfunction

	// four encodings only: move, long call, long jump, pointer load
	function automatic logic is_two_word(input logic [15:0] w);
		is_two_word = (top_of(w) == 4'hc) || (top_of(w) == 4'he && w[11:10] == 2'b11);
	endfunction

	function automatic logic is_long_jump(input logic [15:0] w);
		is_long_jump = (top_of(w) == 4'he) && (w[11:9] == 3'b110 || w[11:8] == 4'hf);
	endfunction

	function automatic logic is_call(input logic [15:0] w);
		is_call = (top_of(w) == 4'he) && (w[11:9] == 3'b110);
	endfunction

	function automatic logic is_skip(input logic [15:0] w);
		is_skip = (w[15:11] == 5'b01100) || (w[15:13] == 3'b101)
			|| (w[15:10] == 6'b001011) || (w[15:10] == 6'b001111)
			|| (w[15:11] == 5'b01001);
	endfunction

	function automatic decode_pkg::instr_class_t classify(input logic [15:0] w, input logic ext);
		logic [3:0] t;
		t = top_of(w);
		classify = decode_pkg::CLS_NOP;
		if (t == `SECOND_WORD_TAG)
			classify = decode_pkg::CLS_NOP;
		else if (t == 4'h0)
		begin
			if (w[11:8] == 4'h0)
				classify = (ext && w == `CALL_INDIRECT_WORD) ? decode_pkg::CLS_EXTENDED
					: decode_pkg::CLS_CONTROL;
			else if (w[11:8] == 4'h1 || w[11])
				classify = decode_pkg::CLS_LITERAL;
			else
				classify = decode_pkg::CLS_BYTE;
		end
		else if (t <= 4'h6)
			classify = decode_pkg::CLS_BYTE;
		else if (t <= 4'hb)
			classify = decode_pkg::CLS_BIT;
		else if (t == 4'hc)
			classify = decode_pkg::CLS_MOVE;
		else if (t == 4'hd)
			classify = decode_pkg::CLS_CONTROL;
		else if (w[11:10] == 2'b10)
			classify = ext ? decode_pkg::CLS_EXTENDED : decode_pkg::CLS_NOP;
		else if (w[11:8] == 4'he)
			classify = decode_pkg::CLS_LITERAL;
		else
			classify = decode_pkg::CLS_CONTROL;
	endfunction

	function automatic decode_pkg::ctl_form_t form_of(input logic [15:0] w);
		if (is_long_jump(w))
			form_of = decode_pkg::FORM_LONG20;
		else if (top_of(w) == 4'hd)
			form_of = decode_pkg::FORM_REL11;
		else if (top_of(w) == 4'he && !w[11])
			form_of = decode_pkg::FORM_SHORT8;
		else
			form_of = decode_pkg::FORM_NONE;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// phase timing

	phase_if ph ();

	instruction_phase_gen #(
		.PHASES(`OSC_PER_CYCLE)
	) u_phase (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.ph(ph)
	);

	wire cycle_end = ph.cycle_end;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer state

	decode_pkg::seq_state_t state;
	decode_pkg::seq_state_t next_state;
	logic [15:0] word1;
	logic [15:0] word2;
	logic [PC_W-1:0] pc;
	logic rd_en;
	logic [15:0] next_word1;
	logic [15:0] next_word2;
	logic [PC_W-1:0] next_pc;

	wire w1_two = is_two_word(word1);
	wire w1_long = is_long_jump(word1);
	wire w1_skip = is_skip(word1);
	wire in_exec = (state == decode_pkg::SEQ_EXEC);
	wire in_second = (state == decode_pkg::SEQ_SECOND);
	wire skip_hit = in_exec && !w1_two && w1_skip && skip_true_i;
	wire jump_hit = ((in_exec && !w1_two) || in_second) && pc_load_i;
	wire [19:0] long_target = {pm_data_i[11:0], word1[7:0]};

	always_comb
	begin
		next_state = state;
		next_word1 = pm_data_i;
		next_word2 = word2;
		unique case (state)
			decode_pkg::SEQ_EXEC:
			begin
				if (w1_two)
				begin
					next_state = decode_pkg::SEQ_SECOND;
					next_word1 = word1;
					next_word2 = pm_data_i;
				end
				else if (jump_hit)
					next_state = decode_pkg::SEQ_FLUSH;
				else if (skip_hit)
					next_state = decode_pkg::SEQ_SKIP;
				else
					next_state = decode_pkg::SEQ_EXEC;
			end
			decode_pkg::SEQ_SECOND:
				next_state = jump_hit ? decode_pkg::SEQ_FLUSH : decode_pkg::SEQ_EXEC;
			decode_pkg::SEQ_FLUSH:
				next_state = decode_pkg::SEQ_EXEC;
			decode_pkg::SEQ_SKIP:
				next_state = w1_two ? decode_pkg::SEQ_SKIP_SECOND : decode_pkg::SEQ_EXEC;
			decode_pkg::SEQ_SKIP_SECOND:
				next_state = decode_pkg::SEQ_EXEC;
			default:
				next_state = decode_pkg::SEQ_FLUSH;
		endcase
	end

	// discarded fetch on a jump: the flush cycle refetches from the new target
	always_comb
	begin
		if (jump_hit)
			next_pc = pc_target_i;
		else if (in_exec && w1_long)
			next_pc = PC_W'(long_target); // target fetched in the second cycle, no extra cycle
		else
			next_pc = PC_W'(pc + PC_W'(1));
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state <= decode_pkg::SEQ_FLUSH;
			word1 <= 16'h0000;
			word2 <= 16'h0000;
			pc <= PC_W'(`RESET_VECTOR);
			rd_en <= 1'b0;
		end
		else
		begin
			rd_en <= 1'b1;
			if (cycle_end)
			begin
				state <= next_state;
				word1 <= next_word1;
				word2 <= next_word2;
				pc <= next_pc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operand fields

	decode_pkg::instr_class_t cls;
	decode_pkg::ctl_form_t form;

	assign cls = classify(word1, extended_en_i);
	assign form = form_of(word1);

	wire [7:0] file_addr = word1[`FILE_MSB:0];
	wire banked = word1[`ACCESS_BIT];
	wire [3:0] access_bank = (file_addr >= `ACCESS_SPLIT) ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK;
	// bank input is read live: a bank change lands at once, on the instruction being decoded
	wire [3:0] bank = banked ? bank_select_register_i : access_bank;

	wire [19:0] short_target = {{12{word1[7]}}, word1[7:0]};
	wire [19:0] rel_target = {{9{word1[10]}}, word1[10:0]};
	wire [19:0] prog_addr = (form == decode_pkg::FORM_LONG20) ? {word2[11:0], word1[7:0]}
		: (form == decode_pkg::FORM_REL11) ? rel_target
		: (form == decode_pkg::FORM_SHORT8) ? short_target : 20'h00000;

	wire executing = (in_exec && !w1_two) || in_second;

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign pm_addr_o = pc;
	assign pm_rd_o = rd_en;
	assign cycle_start_o = ph.cycle_start;
	assign cycle_end_o = cycle_end;
	assign execute_o = executing && (cls != decode_pkg::CLS_NOP);
	assign nop_cycle_o = !execute_o;
	assign second_word_o = in_second;
	assign two_word_o = w1_two;
	assign instr_class_o = cls;
	assign file_addr_o = file_addr;
	assign ram_addr_o = {bank, file_addr};
	assign dest_file_o = word1[`DEST_BIT];
	assign banked_o = banked;
	assign bit_num_o = word1[`BITNUM_MSB:`BITNUM_LSB];
	assign literal_o = word1[7:0];
	assign literal_long_o = {word1[3:0], word2[7:0]};
	assign pointer_sel_o = word1[5:4];
	assign move_src_o = word1[11:0];
	assign move_dst_o = word2[11:0];
	assign prog_addr_o = prog_addr;
	assign fast_o = is_call(word1) ? word1[8] : word1[0];
	assign table_mode_o = word1[1:0];
	assign skip_type_o = w1_skip;

endmodule // mcu_instruction_decode_timing

// [mcu_instruction_decode_timing_assertions.sv]
// checker for instruction cycle timing and operand routing
// assumes it is bound onto the decode block and sees only its ports
`include "mcu_decode_defs.svh"

module mcu_decode_checker #(
	parameter int PC_W = `PC_W_DEFAULT
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [PC_W-1:0] pm_addr_o,
	input wire logic [PC_W-1:0] pc_target_i,
	input wire logic pc_load_i,
	input wire logic skip_true_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic cycle_start_o,
	input wire logic cycle_end_o,
	input wire logic execute_o,
	input wire logic nop_cycle_o,
	input wire logic second_word_o,
	input wire logic two_word_o,
	input wire logic skip_type_o,
	input wire logic banked_o,
	input wire logic [7:0] file_addr_o,
	input wire logic [11:0] ram_addr_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	wire single_end = execute_o && !two_word_o && cycle_end_o;
	wire skip_taken = single_end && skip_type_o && skip_true_i;
	wire jump = cycle_end_o && pc_load_i && execute_o && (second_word_o || !two_word_o);
	//////////////////////////////////////////////////
	sequence s_cycle; !cycle_start_o [*3] ##1 cycle_start_o; endsequence
	sequence s_flush; !execute_o [*4]; endsequence
	property p_phase; cycle_start_o |=> s_cycle; endproperty
	property p_end; cycle_end_o |-> $past(cycle_start_o, 3); endproperty
	property p_stable; !cycle_end_o |=> $stable(pm_addr_o); endproperty
	property p_nop; nop_cycle_o == !execute_o; endproperty
	property p_pair; second_word_o |-> two_word_o && execute_o; endproperty
	property p_second_len; $rose(second_word_o) |-> second_word_o [*4] ##1 !second_word_o; endproperty
	property p_banked; banked_o |-> ram_addr_o == {bank_select_register_i, file_addr_o}; endproperty
	property p_access;
		!banked_o |-> ram_addr_o == {(file_addr_o >= `ACCESS_SPLIT) ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK, file_addr_o};
	endproperty
	property p_plain; single_end && !skip_taken && !pc_load_i |=> pm_addr_o == $past(pm_addr_o) + 1'b1; endproperty
	property p_skip; skip_taken && !pc_load_i |=> s_flush; endproperty
	property p_jump; jump |=> (pm_addr_o == $past(pc_target_i)) ##0 s_flush; endproperty
	a_phase: assert property (p_phase) else $error("cycle start spacing wrong");
	a_end: assert property (p_end) else $error("cycle end not three clocks after start");
	a_stable: assert property (p_stable) else $error("fetch address moved inside a cycle");
	a_nop: assert property (p_nop) else $error("nop flag not inverse of execute");
	a_pair: assert property (p_pair) else $error("second cycle without two-word first word");
	a_second_len: assert property (p_second_len) else $error("second word cycle length wrong");
	a_banked: assert property (p_banked) else $error("banked address wrong");
	a_access: assert property (p_access) else $error("access ram address wrong");
	a_plain: assert property (p_plain) else $error("plain instruction did not advance by one");
	a_skip: assert property (p_skip) else $error("taken skip not followed by a nop cycle");
	a_jump: assert property (p_jump) else $error("loaded target not followed by a nop cycle");
endmodule // mcu_decode_checker

bind mcu_instruction_decode_timing mcu_decode_checker #(.PC_W(PC_W)) chk (.mclk_i, .reset_i, .pm_addr_o,
	.pc_target_i, .pc_load_i, .skip_true_i, .bank_select_register_i, .cycle_start_o, .cycle_end_o, .execute_o,
	.nop_cycle_o, .second_word_o, .two_word_o, .skip_type_o, .banked_o, .file_addr_o, .ram_addr_o);

// [phase_if.sv]
// carries the oscillator phase within an instruction cycle
// assumes at most four phases per instruction cycle
interface phase_if;
	logic [1:0] phase;
	logic cycle_start;
	logic cycle_end;

	modport gen (
		output phase,
		output cycle_start,
		output cycle_end
	);

	modport use_side (
		input phase,
		input cycle_start,
		input cycle_end
	);
endinterface

// [prog_mem_model.sv]
// program memory model answering fetch addresses combinationally
// assumes the bench loads mem before releasing reset
module prog_mem_model (
	input wire logic mclk_i,
	input wire logic pm_rd_i,
	input wire logic [19:0] pm_addr_i,
	output logic [15:0] pm_data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [1024] = '{default: 16'h0000};
	logic [15:0] last = 16'h0000;
	// not reading: toggle each clock so a stale word never looks valid
	assign pm_data_o = pm_rd_i ? mem[pm_addr_i[9:0]] : ~last;
	always_ff @(posedge mclk_i)
	begin
		last <= pm_data_o;
	end
endmodule // prog_mem_model

// [tb_mcu_instruction_decode_timing.sv]
// self-checking bench: one program run through fetch, skip, jump and pairs
// assumes the checker is bound onto the design and the memory model is loaded here
module tb_mcu_instruction_decode_timing;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic skip_true_i = 1'b0;
	logic pc_load_i = 1'b0;
	logic extended_en_i = 1'b0;
	logic [3:0] bank_select_register_i = 4'h0;
	logic [19:0] pc_target_i = 20'h00000;
	logic [19:0] pm_addr_o, prog_addr_o;
	logic [15:0] pm_data_i, w1;
	logic pm_rd_o, cycle_start_o, execute_o, second_word_o, dest_file_o, banked_o;
	logic [7:0] file_addr_o;
	logic [2:0] bit_num_o;
	logic [7:0] literal_o;
	logic [1:0] table_mode_o;
	logic [11:0] move_src_o, move_dst_o;
	decode_pkg::instr_class_t instr_class_o;
	int errors = 0;
	int num_checks = 0;
	int n_to;
	logic [31:0] rnd = 32'h00002082;
	// executed word on top of each note, so field slices can be checked
	logic [63:0] q [$];
	logic [63:0] nt;
	logic [23:0] ent, dat;
	// flags ex/skip/load/second in the top nibble, fetch address below
	localparam logic [23:0] CYC [21] = '{24'h000000, 24'h100001, 24'h100002, 24'h300003, 24'h000004, 24'h300005,
		24'h000006, 24'h000007, 24'h000008, 24'h900009, 24'h00000a, 24'h50000b, 24'h000020, 24'h000021, 24'h900105,
		24'h000106, 24'hd00107, 24'h000200, 24'h100201, 24'h100202, 24'h000203};
	localparam logic [31:0] PROG [18] = '{32'h00002670, 32'h00017520, 32'h00026285, 32'h00032611, 32'h00046340,
		32'h0005c123, 32'h0006f456, 32'h0007cabc, 32'h0008fdef, 32'h0009f123, 32'h000a2412, 32'h0020ef05,
		32'h0021f001, 32'h0105c010, 32'h0106f020, 32'h02002799, 32'h0201e805, 32'h0202e805};
	//////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wait_start;
		n_to = 0;
		do
		begin
			@(posedge mclk_i);
			#1;
			n_to++;
		end
		while (cycle_start_o !== 1'b1 && n_to < 9);
		if (n_to >= 9)
		begin
			errors++;
			test_done();
		end
	endtask
	//////////////////////////////////////////////////
	initial forever #50 mclk_i = ~mclk_i;
	mcu_instruction_decode_timing dut (.mclk_i, .reset_i, .pm_addr_o, .pm_rd_o, .pm_data_i, .bank_select_register_i,
		.extended_en_i, .skip_true_i, .pc_load_i, .pc_target_i, .cycle_start_o, .cycle_end_o(), .execute_o,
		.nop_cycle_o(), .second_word_o, .two_word_o(), .instr_class_o, .file_addr_o, .ram_addr_o(), .dest_file_o,
		.banked_o, .bit_num_o, .literal_o, .literal_long_o(), .pointer_sel_o(), .move_src_o, .move_dst_o,
		.prog_addr_o, .fast_o(), .table_mode_o, .skip_type_o());
	prog_mem_model pm (.mclk_i, .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i));
	initial
	begin
		repeat (8) @(posedge mclk_i);
		foreach (PROG[i]) pm.mem[PROG[i][25:16]] = PROG[i][15:0];
		#1;
		reset_i = 1'b0;
		for (int c = 0; c < 21; c++)
		begin
			if (c > 0) wait_start();
			ent = CYC[c];
			rnd = xs(rnd);
			w1 = pm.mem[ent[9:0] - 10'h1];
			// random skip requests elsewhere must be ignored by non-skip words
			skip_true_i = ent[21] | rnd[20];
			pc_load_i = ent[22];
			pc_target_i = ent[22] ? (ent[19:0] == 20'h0000b ? 20'h00020 : 20'h00200) : rnd[19:0];
			bank_select_register_i = rnd[3:0];
			extended_en_i = (ent[19:0] == 20'h00202);
			if (ent[23]) dat = (ent[19:0] == 20'h00105) ? 24'h000105 : {pm.mem[ent[9:0] - 10'h2][11:0], w1[11:0]};
			else dat = {11'h0, (ent[19:0] == 20'h00202) ? decode_pkg::CLS_EXTENDED
				: (w1[15:12] >= 4'h7) ? decode_pkg::CLS_BIT : decode_pkg::CLS_BYTE, w1[9:0]};
			q.push_back({w1, ent, dat});
		end
		repeat (8) @(posedge mclk_i);
		`CHK("notes left", 0, q.size())
		$display("program run done");
		test_done();
	end
	always @(posedge mclk_i)
	begin
		#3;
		if (!reset_i && cycle_start_o === 1'b1 && q.size() > 0)
		begin
			nt = q.pop_front();
			`CHK("cycle", ({nt[44], nt[47], nt[43:24]}), ({execute_o, second_word_o, pm_addr_o}))
			if (nt[44] && nt[47]) `CHK("pair", nt[23:0], ((instr_class_o === decode_pkg::CLS_MOVE) ? {move_src_o, move_dst_o} : {4'h0, prog_addr_o}))
			else if (nt[44])
			begin
				`CHK("fields", nt[23:0], ({11'h0, instr_class_o, dest_file_o, banked_o, file_addr_o}))
				`CHK("bit", nt[59:57], bit_num_o)
				`CHK("literal", nt[55:48], literal_o)
				`CHK("table", nt[49:48], table_mode_o)
				`CHK("read", 1'b1, pm_rd_o)
			end
		end
	end
endmodule // tb_mcu_instruction_decode_timing
